// [verif/msp_master_spi_checker.sv]
// Port-level assertions for the master SPI transfer block
`timescale 1ns/1ps
module msp_master_spi_checker
  import msp_pkg::*;
(
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic [1:0] operating_mode_field,
  input wire logic transmitter_enable,
  input wire logic receiver_enable,
  input wire logic clock_pin_direction,
  input wire logic divisor_wr,
  input wire logic [DIV_WIDTH-1:0] divisor_wdata,
  input wire logic data_wr,
  input wire logic [DIV_WIDTH-1:0] clock_divisor,
  input wire logic transmit_complete_flag,
  input wire logic receive_complete_flag,
  input wire logic tx_buffer_empty_flag,
  input wire logic frame_error_flag,
  input wire logic data_overrun_flag,
  input wire logic parity_error_flag,
  input wire logic master_spi_mode,
  input wire logic serial_clock_pin,
  input wire logic serial_clock_oe,
  input wire logic serial_out_oe,
  input wire logic serial_in_owned
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  a_err_zero: assert property (!(frame_error_flag |
    data_overrun_flag | parity_error_flag))
    else $error("receiver error flag set");
  a_mode_decode: assert property (master_spi_mode ==
    (operating_mode_field == MODE_MASTER_SPI)) else $error("mode decode");
  a_div_load: assert property (divisor_wr && clk_en |=>
    clock_divisor == $past(divisor_wdata)) else $error("divisor not loaded");
  // A half period of three cycles is the case the bench runs most
  a_half_period: assert property ($changed(serial_clock_pin) &&
    clock_divisor == 12'h002 |=> !$changed(serial_clock_pin) [*2])
    else $error("serial clock half period short");
  a_out_owned: assert property (
    (transmitter_enable && master_spi_mode) [*2] |-> serial_out_oe)
    else $error("output pin not taken");
  a_in_owned: assert property ((receiver_enable && master_spi_mode)
    [*2] |-> serial_in_owned) else $error("input pin not taken");
  a_clk_dir: assert property (serial_clock_oe == clock_pin_direction)
    else $error("clock pin direction");
  a_hold_fill: assert property (data_wr && clk_en &&
    master_spi_mode && tx_buffer_empty_flag |=> !tx_buffer_empty_flag)
    else $error("no hold");
  a_mode_refuse: assert property (!master_spi_mode &&
    tx_buffer_empty_flag |=> tx_buffer_empty_flag) else $error("write taken");
  a_rx_flush: assert property (!receiver_enable [*2] |->
    !receive_complete_flag) else $error("receive buffer not flushed");
  c_txc: cover property ($rose(transmit_complete_flag));
  c_fill: cover property ($fell(tx_buffer_empty_flag));
  c_div: cover property (divisor_wr);
endmodule // msp_master_spi_checker

bind msp_master_spi msp_master_spi_checker u_chk (.mclk(mclk),
  .reset_n(reset_n), .clk_en(clk_en),
  .operating_mode_field(operating_mode_field),
  .transmitter_enable(transmitter_enable),
  .receiver_enable(receiver_enable),
  .clock_pin_direction(clock_pin_direction), .divisor_wr(divisor_wr),
  .divisor_wdata(divisor_wdata), .data_wr(data_wr),
  .clock_divisor(clock_divisor),
  .transmit_complete_flag(transmit_complete_flag),
  .receive_complete_flag(receive_complete_flag),
  .tx_buffer_empty_flag(tx_buffer_empty_flag),
  .frame_error_flag(frame_error_flag),
  .data_overrun_flag(data_overrun_flag),
  .parity_error_flag(parity_error_flag),
  .master_spi_mode(master_spi_mode),
  .serial_clock_pin(serial_clock_pin),
  .serial_clock_oe(serial_clock_oe), .serial_out_oe(serial_out_oe),
  .serial_in_owned(serial_in_owned));

// [verif/msp_master_spi_tb_top.sv]
// Self-checking bench for the master SPI transfer block
`timescale 1ns/1ps
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin miscompares++; \
  $display("[FAIL] %s expected %0h seen %0h", n, e, g); end end
module msp_master_spi_tb_top;
  import msp_pkg::*;
  logic mclk = 0, reset_n = 0, clk_en = 1, armed = 0;
  logic [1:0] operating_mode_field = 2'h3;
  logic bit_order_select = 0, clock_phase_select = 0;
  logic clock_polarity_select = 0, clock_pin_direction = 0;
  logic transmitter_enable = 0, receiver_enable = 0, data_rd = 0;
  logic divisor_wr = 0, data_wr = 0, tx_complete_clr = 0;
  logic [DIV_WIDTH-1:0] divisor_wdata = 12'h000, clock_divisor;
  logic [7:0] data_wdata = 8'h00, reply = 8'h00, data_rdata;
  logic serial_in_pin, transmit_complete_flag, receive_complete_flag;
  logic tx_buffer_empty_flag, frame_error_flag, data_overrun_flag;
  logic parity_error_flag, master_spi_mode, serial_clock_pin;
  logic serial_clock_oe, serial_out_pin, serial_out_oe, serial_in_owned;
  int miscompares = 0, cmp_count = 0, edges = 0;
  always #5 mclk = ~mclk;
  always @(serial_clock_pin) if (armed) edges++;
  msp_master_spi u_dut (.mclk(mclk), .reset_n(reset_n), .clk_en(clk_en),
    .operating_mode_field(operating_mode_field),
    .bit_order_select(bit_order_select),
    .clock_phase_select(clock_phase_select),
    .clock_polarity_select(clock_polarity_select),
    .transmitter_enable(transmitter_enable),
    .receiver_enable(receiver_enable),
    .clock_pin_direction(clock_pin_direction), .divisor_wr(divisor_wr),
    .divisor_wdata(divisor_wdata), .data_wr(data_wr),
    .data_wdata(data_wdata), .data_rd(data_rd),
    .tx_complete_clr(tx_complete_clr), .serial_in_pin(serial_in_pin),
    .data_rdata(data_rdata), .clock_divisor(clock_divisor),
    .transmit_complete_flag(transmit_complete_flag),
    .receive_complete_flag(receive_complete_flag),
    .tx_buffer_empty_flag(tx_buffer_empty_flag),
    .frame_error_flag(frame_error_flag),
    .data_overrun_flag(data_overrun_flag),
    .parity_error_flag(parity_error_flag),
    .master_spi_mode(master_spi_mode),
    .serial_clock_pin(serial_clock_pin),
    .serial_clock_oe(serial_clock_oe), .serial_out_pin(serial_out_pin),
    .serial_out_oe(serial_out_oe), .serial_in_owned(serial_in_owned));
  msp_spi_slave u_slv (.sck(serial_clock_pin), .mosi(serial_out_pin),
    .miso(serial_in_pin), .armed(armed), .cpol(clock_polarity_select),
    .cpha(clock_phase_select), .lsb(bit_order_select), .reply(reply));
  // cfg holds receiver enable, bit order, phase and polarity
  task automatic init(input logic [3:0] cfg, input logic [11:0] div);
    @(posedge mclk);
    reset_n <= 0;
    armed <= 0;
    {bit_order_select, clock_phase_select,
      clock_polarity_select} <= cfg[2:0]; // only while in reset
    transmitter_enable <= 0;
    receiver_enable <= 0;
    clock_pin_direction <= 1;
    repeat (2) @(posedge mclk);
    reset_n <= 1;
    @(posedge mclk);
    `CHK("divisor reset", 12'h000, clock_divisor);
    `CHK("out idle", 1'b1, serial_out_pin);
    `CHK("err flags", 3'h0, {frame_error_flag, data_overrun_flag,
      parity_error_flag});
    transmitter_enable <= 1;
    receiver_enable <= cfg[3];
    @(posedge mclk);
    divisor_wr <= 1;
    divisor_wdata <= div;
    @(posedge mclk);
    divisor_wr <= 0;
    armed <= 1;
    edges = 0;
    @(posedge mclk);
    `CHK("divisor", div, clock_divisor);
  endtask
  task automatic wr(input logic [7:0] d);
    // Look only after an edge, so a write taken at the last edge counts
    do @(posedge mclk); while (tx_buffer_empty_flag !== 1'b1);
    tx_complete_clr <= 1;
    @(posedge mclk);
    tx_complete_clr <= 0;
    data_wr <= 1;
    data_wdata <= d;
    @(posedge mclk);
    data_wr <= 0;
  endtask
  task automatic rd(input logic [7:0] e);
    @(posedge mclk);
    data_rd <= 1;
    @(posedge mclk);
    data_rd <= 0;
    @(posedge mclk);
    `CHK("read data", e, data_rdata);
  endtask
  task automatic wait_done(input bit txc);
    for (int i = 0; i < 3000; i++) begin
      @(posedge mclk);
      if ((txc ? transmit_complete_flag : receive_complete_flag) === 1'b1)
        break;
    end
  endtask
  task automatic t_modes();
    for (int m = 0; m < 8; m++) begin
      reply <= 8'hA5 + 8'(m);
      init({1'b1, m[2:0]}, 12'h002 + 12'(m[1]));
      wr(8'h3C ^ 8'(m));
      wait_done(0);
      `CHK("rx done", 1'b1, receive_complete_flag);
      `CHK("edges", 16, edges);
      `CHK("tx done", 1'b1, transmit_complete_flag);
      `CHK("out idle after", 1'b1, serial_out_pin);
      `CHK("sck idle", m[0], serial_clock_pin);
      `CHK("slave got", 8'h3C ^ 8'(m), u_slv.got[0]);
      rd(8'hA5 + 8'(m));
    end
  endtask
  task automatic t_b2b();
    reply <= 8'h10;
    init(4'h8, 12'h002);
    wr(8'h81);
    wr(8'h42);
    @(posedge mclk);
    `CHK("hold full", 1'b0, tx_buffer_empty_flag);
    wait_done(0);
    `CHK("txc mid word", 1'b0, transmit_complete_flag);
    rd(8'h10);
    wait_done(1);
    `CHK("edges", 32, edges);
    rd(8'h11);
    `CHK("slave got", 8'h42, u_slv.got[1]);
  endtask
  task automatic t_overflow();
    reply <= 8'h20;
    init(4'h8, 12'h002);
    for (int i = 0; i < 4; i++) wr(8'(i));
    wait_done(1);
    rd(8'h20);
    rd(8'h21);
    rd(8'h23);
  endtask
  task automatic t_gate();
    int e0;
    init(4'h0, 12'h002);
    wr(8'h5A);
    // Freeze mid-frame: the clock pin and the flags must not move
    repeat (5) @(posedge mclk);
    clk_en <= 0;
    repeat (2) @(posedge mclk);
    e0 = edges;
    repeat (30) @(posedge mclk);
    `CHK("frozen edges", e0, edges);
    `CHK("frozen txc", 1'b0, transmit_complete_flag);
    clk_en <= 1;
    wait_done(1);
    `CHK("rx off", 1'b0, receive_complete_flag);
    `CHK("in owned", 1'b0, serial_in_owned);
    `CHK("edges", 16, edges);
    `CHK("slave got", 8'h5A, u_slv.got[0]);
    for (int k = 0; k < 3; k++) begin
      operating_mode_field <= 2'(k);
      wr(8'h77);
      repeat (40) @(posedge mclk);
      `CHK("mode off", 1'b0, master_spi_mode);
      `CHK("no frame", 16, edges);
    end
    operating_mode_field <= 2'h3;
    transmitter_enable <= 0;
    wr(8'h66);
    repeat (60) @(posedge mclk);
    `CHK("no tx clock", 16, edges);
  endtask
  task automatic give_verdict();
    $display("comparisons %0d miscompares %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    t_modes();
    t_b2b();
    t_overflow();
    t_gate();
    give_verdict();
  end
  // The tests need well under 20000 cycles
  initial begin
    #400000;
    miscompares++;
    give_verdict();
  end
endmodule // msp_master_spi_tb_top

// [verif/msp_spi_slave.sv]
// Behavioural SPI slave facing the master transfer block
`timescale 1ns/1ps
module msp_spi_slave (
  input wire logic sck,
  input wire logic mosi,
  output logic miso = 1'b1,
  input wire logic armed,
  input wire logic cpol,
  input wire logic cpha,
  input wire logic lsb,
  input wire logic [7:0] reply
);
  logic [7:0] sh = 8'h00;
  logic [7:0] got[$];
  int ns = 0;
  int nr = 0;
  // Byte n of a burst answers reply plus n, so a lost byte shows
  function automatic logic pick(input int s);
    logic [7:0] v;
    v = reply + 8'(s / 8);
    return lsb ? v[s % 8] : v[7 - s % 8];
  endfunction
  // Phase 0 samples on its first edge, so bit 0 is preloaded
  always @(posedge armed) begin
    ns = cpha ? 0 : 1;
    nr = 0;
    got.delete();
    miso = pick(0);
  end
  always @(sck) begin
    if (armed && ((sck != cpol) == !cpha)) begin
      sh = lsb ? {mosi, sh[7:1]} : {sh[6:0], mosi};
      nr++;
      if (nr % 8 == 0) got.push_back(sh);
    end else if (armed) begin
      // Change only on setup edges; the master sees the pin late
      miso = pick(ns);
      ns++;
    end
  end
endmodule // msp_spi_slave

// [verilog/msp_buf_if.sv]
// Handshake bundle between the receive buffer and the transfer engine
`timescale 1ns/1ps
interface msp_buf_if #(parameter int WIDTH = 8);
  logic in_valid;
  logic in_ready;
  logic [WIDTH-1:0] in_data;
  logic out_valid;
  logic out_ready;
  logic [WIDTH-1:0] out_data;
  logic flush;
  modport fill (output in_valid, output in_data, input in_ready,
    output flush);
  modport drain (input out_valid, input out_data, output out_ready);
  modport buffer (input in_valid, input in_data, output in_ready,
    output out_valid, output out_data, input out_ready, input flush);
endinterface

// [verilog/msp_master_spi.sv]
// Master SPI transfer engine of the serial transceiver
//
// Notes on behaviour
// - Every frame is exactly eight data bits, no start, stop or parity.
// - One bit-order control governs both transmit and receive shifting.
// - After a frame, start next queued byte at once or idle output high.
// - Two back-to-back writes form 16 bits; complete flag after both.
// - Clock divisor resets to zero.
// - Receiver alone cannot run; only transmitter operates independently.
// - Transmitter enable required; it takes over the serial output pin.
// - Receiver enable optional; it takes over the serial input pin.
// - Serial clock pin is transfer clock whether receiver on or off.
// - Data write starts full-duplex transfer; no separate receive trigger.
// - Queued byte moves to shifter as soon as the shifter is free.
// - On receive overflow the waiting byte is overwritten by the newest; buffered ones kept.
// - Frame, overrun and parity error flags always read zero.
// - Transmit path has a holding buffer in front of the shifter.
// - Receive path has a pending register and a two-entry buffer beyond the shift register.
// - No write collision flag, no clock doubling; speed via divisor.
// - Polarity, phase and bit order behave as standard SPI controls.
// - Bit order one sends LSB first; zero sends MSB first.
// - Master SPI selected only when operating mode field is binary 11.
// - Serial clock rate is system clock over two times (divisor plus one).
// - Drive data on one clock edge, sample on the opposite edge.
`timescale 1ns/1ps
module msp_master_spi
  import msp_pkg::*;
(
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic [1:0] operating_mode_field,
  input wire logic bit_order_select,
  input wire logic clock_phase_select,
  input wire logic clock_polarity_select,
  input wire logic transmitter_enable,
  input wire logic receiver_enable,
  input wire logic clock_pin_direction,
  input wire logic divisor_wr,
  input wire logic [DIV_WIDTH-1:0] divisor_wdata,
  input wire logic data_wr,
  input wire logic [FRAME_BITS-1:0] data_wdata,
  input wire logic data_rd,
  input wire logic tx_complete_clr,
  input wire logic serial_in_pin,
  output logic [FRAME_BITS-1:0] data_rdata,
  output logic [DIV_WIDTH-1:0] clock_divisor,
  output logic transmit_complete_flag,
  output logic receive_complete_flag,
  output logic tx_buffer_empty_flag,
  output logic frame_error_flag,
  output logic data_overrun_flag,
  output logic parity_error_flag,
  output logic master_spi_mode,
  output logic serial_clock_pin,
  output logic serial_clock_oe,
  output logic serial_out_pin,
  output logic serial_out_oe,
  output logic serial_in_owned
);
  msp_state_type state_q;
  logic [DIV_WIDTH-1:0] div_q;
  logic [DIV_WIDTH-1:0] baud_cnt_q;
  logic [FRAME_BITS-1:0] hold_q;
  logic hold_full_q;
  logic [FRAME_BITS-1:0] tx_shift_q;
  logic [FRAME_BITS-1:0] rx_shift_q;
  logic [BIT_CNT_WIDTH-1:0] bit_cnt_q;
  logic sck_q;
  logic mosi_q;
  logic txc_q;
  logic [FRAME_BITS-1:0] rdata_q;
  logic miso_meta_q;
  logic miso_sync_q;
  logic tick;
  logic active;
  logic load;
  logic frame_done;
  logic sample_bit;
  logic [FRAME_BITS-1:0] rx_pend_q;
  logic rx_pend_full_q;

  msp_buf_if #(.WIDTH(FRAME_BITS)) rxb ();

  msp_rx_buf #(.WIDTH(FRAME_BITS), .DEPTH(RX_DEPTH)) u_rx_buf (
    .mclk(mclk),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .bus(rxb.buffer)
  );

  // Next bit to present on the line, per the shared order control
  function automatic logic out_bit(input logic [FRAME_BITS-1:0] v,
                                   input logic lsb_first);
    out_bit = lsb_first ? v[0] : v[FRAME_BITS-1];
  endfunction

  // Shift one step, entering the new bit from the far end
  function automatic logic [FRAME_BITS-1:0] shift_step(
      input logic [FRAME_BITS-1:0] v, input logic in_bit,
      input logic lsb_first);
    shift_step = lsb_first ? {in_bit, v[FRAME_BITS-1:1]}
                           : {v[FRAME_BITS-2:0], in_bit};
  endfunction

  assign master_spi_mode = (operating_mode_field == MODE_MASTER_SPI);
  // Receiver without transmitter gives no clock, so nothing runs
  assign active = master_spi_mode && transmitter_enable;
  assign tick = (baud_cnt_q == '0);
  assign load = active && hold_full_q && (state_q == MSP_IDLE);
  assign frame_done = tick && (state_q == MSP_TRAIL)
    && (bit_cnt_q == HALF_EDGES - 4'h1);
  // Sample edge is the leading edge for phase 0, trailing for phase 1
  assign sample_bit = tick && ((state_q == MSP_LEAD) != clock_phase_select);

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      miso_meta_q <= 1'b0;
      miso_sync_q <= 1'b0;
    end else if (clk_en) begin
      miso_meta_q <= serial_in_pin;
      miso_sync_q <= miso_meta_q;
    end
  end

  // Divisor register; speed is only ever set here
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      div_q <= DIV_RESET;
    end else if (clk_en && divisor_wr) begin
      div_q <= divisor_wdata;
    end
  end

  // Half-period counter; a write reloads it so the new rate acts at once
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      baud_cnt_q <= DIV_RESET;
    end else if (clk_en) begin
      if (divisor_wr || tick || state_q == MSP_IDLE) begin
        baud_cnt_q <= divisor_wr ? divisor_wdata : div_q;
      end else begin
        baud_cnt_q <= baud_cnt_q - 1'b1;
      end
    end
  end

  // Holding buffer in front of the shifter
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      hold_q <= BYTE_ZERO;
      hold_full_q <= 1'b0;
    end else if (clk_en) begin
      if (data_wr && !hold_full_q && master_spi_mode) begin
        hold_q <= data_wdata;
        hold_full_q <= 1'b1;
      // A byte queued while the transmitter is off waits for re-enable
      end else if (load || (frame_done && hold_full_q && active)) begin
        hold_full_q <= 1'b0;
      end
    end
  end

  // Frame sequencer: leading half then trailing half per bit
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= MSP_IDLE;
      bit_cnt_q <= '0;
      tx_shift_q <= BYTE_ZERO;
    end else if (clk_en) begin
      case (state_q)
        MSP_IDLE: begin
          if (load) begin
            state_q <= MSP_LEAD;
            bit_cnt_q <= '0;
            tx_shift_q <= hold_q;
          end
        end
        MSP_LEAD: begin
          if (tick) begin
            state_q <= MSP_TRAIL;
          end
        end
        MSP_TRAIL: begin
          if (tick) begin
            if (frame_done) begin
              if (hold_full_q && active) begin
                state_q <= MSP_LEAD; // back-to-back frame
                bit_cnt_q <= '0;
                tx_shift_q <= hold_q;
              end else begin
                state_q <= MSP_IDLE;
              end
            end else begin
              state_q <= MSP_LEAD;
              bit_cnt_q <= bit_cnt_q + 1'b1;
              tx_shift_q <= shift_step(tx_shift_q, 1'b0, bit_order_select);
            end
          end
        end
        default: begin
          state_q <= MSP_IDLE;
        end
      endcase
    end
  end

  // Clock toggles only inside a frame; idle level from polarity
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      sck_q <= 1'b0;
    end else if (clk_en) begin
      if (state_q == MSP_IDLE) begin
        sck_q <= clock_polarity_select;
      end else if (tick) begin
        sck_q <= ~sck_q;
      end
    end
  end

  // Data output: with phase 0 the first bit is set up before the first edge
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      mosi_q <= 1'b1;
    end else if (clk_en) begin
      if (load) begin
        mosi_q <= clock_phase_select ? mosi_q
                  : out_bit(hold_q, bit_order_select);
      end else if (state_q == MSP_IDLE) begin
        mosi_q <= 1'b1; // idle high
      end else if (tick && !sample_bit) begin
        // Setup edge drives the bit opposite to the sampling edge
        if (clock_phase_select && state_q == MSP_LEAD) begin
          mosi_q <= out_bit(tx_shift_q, bit_order_select);
        end else if (!clock_phase_select && !frame_done) begin
          mosi_q <= out_bit(shift_step(tx_shift_q, 1'b0, bit_order_select),
                            bit_order_select);
        end else if (frame_done && hold_full_q && active) begin
          mosi_q <= out_bit(hold_q, bit_order_select);
        end
      end
    end
  end

  // Receive shifter, fed only on sample edges
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rx_shift_q <= BYTE_ZERO;
    end else if (clk_en && sample_bit) begin
      rx_shift_q <= shift_step(rx_shift_q, miso_sync_q, bit_order_select);
    end
  end

  // Completed byte: phase 1 samples on the final edge itself
  logic [FRAME_BITS-1:0] rx_final;
  assign rx_final = clock_phase_select
    ? shift_step(rx_shift_q, miso_sync_q, bit_order_select) : rx_shift_q;

  // Completed byte waits here, as in a shift register, until the buffer
  // has room; a newer byte overwrites it, so the byte caught behind a
  // full buffer is lost while the older buffered bytes stay
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rx_pend_q <= BYTE_ZERO;
      rx_pend_full_q <= 1'b0;
    end else if (clk_en) begin
      if (!receiver_enable) begin
        rx_pend_full_q <= 1'b0;
      end else if (frame_done) begin
        rx_pend_q <= rx_final;
        rx_pend_full_q <= 1'b1;
      end else if (rxb.in_ready) begin
        rx_pend_full_q <= 1'b0;
      end
    end
  end

  assign rxb.in_valid = rx_pend_full_q;
  assign rxb.in_data = rx_pend_q;
  assign rxb.flush = !receiver_enable;
  assign rxb.out_ready = data_rd && clk_en;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rdata_q <= BYTE_ZERO;
    end else if (clk_en && data_rd) begin
      rdata_q <= rxb.out_valid ? rxb.out_data : BYTE_ZERO;
    end
  end

  // Transmit complete: set when the shifter empties with the holding buffer empty or the transmitter off
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      txc_q <= 1'b0;
    end else if (clk_en) begin
      if (frame_done && !(hold_full_q && active)) begin
        txc_q <= 1'b1; // set beats clear
      end else if (tx_complete_clr) begin
        txc_q <= 1'b0;
      end
    end
  end

  assign data_rdata = rdata_q;
  assign clock_divisor = div_q;
  assign transmit_complete_flag = txc_q;
  assign receive_complete_flag = rxb.out_valid;
  assign tx_buffer_empty_flag = !hold_full_q;
  assign frame_error_flag = 1'b0;
  assign data_overrun_flag = 1'b0;
  assign parity_error_flag = 1'b0;
  assign serial_clock_pin = sck_q;
  assign serial_clock_oe = clock_pin_direction;
  assign serial_out_pin = mosi_q;
  assign serial_out_oe = transmitter_enable && master_spi_mode;
  assign serial_in_owned = receiver_enable && master_spi_mode;
endmodule // msp_master_spi

// [verilog/msp_pkg.sv]
// Constants and types shared by the master SPI transfer block
package msp_pkg;
  localparam int FRAME_BITS = 8;
  localparam int DIV_WIDTH = 12;
  localparam logic [DIV_WIDTH-1:0] DIV_RESET = 12'h000;
  localparam logic [1:0] MODE_MASTER_SPI = 2'h3;
  localparam logic [1:0] MODE_ASYNC = 2'h0;
  localparam logic [1:0] MODE_SYNC = 2'h1;
  localparam int BIT_CNT_WIDTH = 4;
  localparam logic [BIT_CNT_WIDTH-1:0] HALF_EDGES = 4'h8;
  localparam int RX_DEPTH = 2;
  localparam int TX_DEPTH = 2;
  localparam int RX_CNT_WIDTH = 2;
  localparam logic [7:0] BYTE_ZERO = 8'h00;

  typedef enum logic [2:0] {
    MSP_IDLE = 3'b001,
    MSP_LEAD = 3'b010,
    MSP_TRAIL = 3'b100
  } msp_state_type;
endpackage

// [verilog/msp_rx_buf.sv]
// Two-entry receive buffer with valid/ready on both sides
`timescale 1ns/1ps
module msp_rx_buf
  import msp_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = RX_DEPTH
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic clk_en,
  msp_buf_if.buffer bus
);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [RX_CNT_WIDTH-1:0] count_q;
  logic rd_ptr_q;
  logic wr_ptr_q;
  logic push;
  logic pop;

  assign bus.in_ready = (count_q != RX_CNT_WIDTH'(DEPTH));
  assign bus.out_valid = (count_q != '0);
  assign bus.out_data = mem_q[rd_ptr_q];
  assign push = bus.in_valid && bus.in_ready;
  assign pop = bus.out_valid && bus.out_ready;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      count_q <= '0;
      rd_ptr_q <= 1'b0;
      wr_ptr_q <= 1'b0;
    end else if (clk_en) begin
      if (bus.flush) begin
        count_q <= '0;
        rd_ptr_q <= 1'b0;
        wr_ptr_q <= 1'b0;
      end else begin
        if (push) begin
          wr_ptr_q <= ~wr_ptr_q;
        end
        if (pop) begin
          rd_ptr_q <= ~rd_ptr_q;
        end
        if (push && !pop) begin
          count_q <= count_q + 1'b1;
        end else if (pop && !push) begin
          count_q <= count_q - 1'b1;
        end
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (clk_en && push) begin
      mem_q[wr_ptr_q] <= bus.in_data;
    end
  end
endmodule // msp_rx_buf
